// [hdl/timer_pkg.sv]
/*
 * Package for the dual timer/counter block: register addresses, reset values,
 * field positions, counting modes, interrupt vectors and the carrier structs.
 * Assumes an 8-bit register address space with byte-wide registers.
 */
package timer_pkg;

   // ----------------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_TIMER_CONTROL_FLAGS       = 8'h88;
   localparam logic [7:0] ADDR_TIMER_MODE_SELECT         = 8'h89;
   localparam logic [7:0] ADDR_TIMER0_COUNT_LOW          = 8'h8A;
   localparam logic [7:0] ADDR_TIMER1_COUNT_LOW          = 8'h8B;
   localparam logic [7:0] ADDR_TIMER0_COUNT_HIGH         = 8'h8C;
   localparam logic [7:0] ADDR_TIMER1_COUNT_HIGH         = 8'h8D;
   localparam logic [7:0] ADDR_INTERRUPT_ENABLE_MASK     = 8'hA8;
   localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_SELECT = 8'hB8;

   // ----------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------
   localparam logic [7:0] RST_CONTROL_FLAGS = 8'h00;
   localparam logic [7:0] RST_MODE_SELECT   = 8'h00;
   localparam logic [7:0] RST_COUNT         = 8'h00;
   localparam logic [7:0] RST_IRQ_ENABLE    = 8'h00;
   localparam logic [7:0] RST_IRQ_PRIORITY  = 8'h00;
   localparam logic [7:0] UNMAPPED_READ     = 8'h00;

   // ----------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------
   localparam int BIT_TIMER1_OVERFLOW_FLAG = 7;
   localparam int BIT_TIMER1_RUN_BIT       = 6;
   localparam int BIT_TIMER0_OVERFLOW_FLAG = 5;
   localparam int BIT_TIMER0_RUN_BIT       = 4;
   localparam int BIT_TIMER1_GATE_ENABLE   = 7;
   localparam int BIT_TIMER1_SOURCE_SELECT = 6;
   localparam int BIT_TIMER1_MODE_HIGH     = 5;
   localparam int BIT_TIMER1_MODE_LOW      = 4;
   localparam int BIT_TIMER0_GATE_ENABLE   = 3;
   localparam int BIT_TIMER0_SOURCE_SELECT = 2;
   localparam int BIT_TIMER0_MODE_HIGH     = 1;
   localparam int BIT_TIMER0_MODE_LOW      = 0;
   localparam int BIT_GLOBAL_IRQ_ENABLE    = 7;
   localparam int BIT_TIMER1_IRQ_ENABLE    = 3;
   localparam int BIT_TIMER0_IRQ_ENABLE    = 1;
   localparam int BIT_TIMER1_IRQ_PRIORITY  = 3;
   localparam int BIT_TIMER0_IRQ_PRIORITY  = 1;
   localparam logic [7:0] PRIORITY_IMPL_MASK = 8'h3F;

   // ----------------------------------------------------------------------
   // Counting constants and interrupt vectors
   // ----------------------------------------------------------------------
   localparam logic [3:0]  TIMER_TICK_CYCLES = 4'hC;
   localparam logic [3:0]  TIMER_TICK_LAST   = TIMER_TICK_CYCLES - 4'h1;
   localparam logic [15:0] TIMER0_VECTOR     = 16'h000B;
   localparam logic [15:0] TIMER1_VECTOR     = 16'h001B;
   localparam int          TIMER0_NATURAL_PRIORITY = 2;
   localparam int          TIMER1_NATURAL_PRIORITY = 4;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_13BIT  = 2'b00,
      MODE_16BIT  = 2'b01,
      MODE_RELOAD = 2'b10,
      MODE_SPLIT  = 2'b11
   } mode_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_s;

   typedef struct packed {
      logic [7:0] hi;
      logic [7:0] lo;
      logic       ovf;
   } cnt_s;

endpackage

// [hdl/dual_timer_counter_block.sv]
/*
 * Two 16-bit timer/counters with four modes each, pin synchronisers,
 * a divide-by-twelve tick, overflow flags and interrupt request outputs.
 * Assumes a processor-side register port with read data one cycle later
 * and an acknowledge pulse carrying the vector being entered.
 */
// Operation
// - Two-bit mode field picks 13-bit, 16-bit, 8-bit reload or split mode.
// - Mode 0 counts high register above low five bits of low register.
// - Timer 1 low register top three bits are ignored in mode 0.
// - Roll-over of all valid bits in 13-bit mode sets the overflow flag.
// - Mode 1 cascades high and low registers into one 16-bit counter.
// - Mode 2 low register counts; overflow sets flag and reloads from high.
// - Split mode: timer 0 low uses timer 0 controls and flag.
// - Split mode: timer 0 high counts ticks, runs on timer 1 run bit, sets flag 1.
// - Timer 1 in mode 3 holds its count.
// - With timer 0 split, timer 1 still counts and emits overflow pulses.
// - Timer 0 counts when run bit set and gate disabled or gate pin high.
// - Timer 1 counts when run bit set and gate disabled or gate pin high.
// - Timer 1 gate-enable is mode bit 7, gating by its gate pin.
// - Source select 1 counts count-pin falling edges, 0 counts internal ticks.
// - Internal tick advances the count once per twelve clocks.
// - Count pins are sampled every clock; falls found from successive samples.
// - Entering a timer vector clears its overflow flag; vectors 0x0B, 0x1B.
// - Software can set or clear interrupt flags just like hardware.
// - Request needs global enable bit 7 and timer enable bit 1 or 3.
// - Priority register holds bits 5 to 0, outputs use bits 1 and 3; top two bits read zero.
`timescale 1ns/100ps

module dual_timer_counter_block (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              resetn,
   // Register port
   input  wire timer_pkg::reg_req_s reg_req,
   output logic [7:0]             reg_rdata,
   // Interrupt acknowledge
   input  wire logic              irq_ack,
   input  wire logic [15:0]       irq_ack_vector,
   // External pins
   input  wire logic              timer0_count_pin,
   input  wire logic              timer1_count_pin,
   input  wire logic              timer0_gate_pin,
   input  wire logic              timer1_gate_pin,
   // Interrupt and overflow outputs
   output logic                   timer0_irq_req,
   output logic                   timer1_irq_req,
   output logic                   timer0_irq_high,
   output logic                   timer1_irq_high,
   output logic                   timer1_overflow_pulse
);
   import timer_pkg::*;

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [7:0] timer_control_flags_q;
   logic [7:0] timer_control_flags_d;
   logic [7:0] timer_mode_select_q;
   logic [7:0] timer0_count_low_q;
   logic [7:0] timer0_count_low_d;
   logic [7:0] timer0_count_high_q;
   logic [7:0] timer0_count_high_d;
   logic [7:0] timer1_count_low_q;
   logic [7:0] timer1_count_low_d;
   logic [7:0] timer1_count_high_q;
   logic [7:0] timer1_count_high_d;
   logic [7:0] interrupt_enable_mask_q;
   logic [7:0] interrupt_priority_select_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [3:0] tick_cnt_q;
   logic       irq0_q;
   logic       irq1_q;
   logic       ovf_pulse_q;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   // Index 0/1 are count pins, 2/3 are gate pins.
   logic [3:0] pin_raw;
   logic [3:0] pin_filt;
   logic [3:0] pin_fall;

   assign pin_raw = {timer1_gate_pin, timer0_gate_pin, timer1_count_pin, timer0_count_pin};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pin_sync
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic filt_q;
         logic prev_q;
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               s1_q   <= 1'b0;
               s2_q   <= 1'b0;
               s3_q   <= 1'b0;
               filt_q <= 1'b0;
               prev_q <= 1'b0;
            end else begin
               s1_q   <= pin_raw[gi];
               s2_q   <= s1_q;
               s3_q   <= s2_q;
               // A change is taken once the second and third stages agree.
               filt_q <= (s2_q == s3_q) ? s2_q : filt_q;
               prev_q <= filt_q;
            end
         end
         assign pin_filt[gi] = filt_q;
         assign pin_fall[gi] = prev_q & ~filt_q;
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Internal tick
   // ----------------------------------------------------------------------
   wire tick = (tick_cnt_q == TIMER_TICK_LAST);

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tick_cnt_q <= 4'h0;
      end else begin
         tick_cnt_q <= tick ? 4'h0 : tick_cnt_q + 4'h1;
      end
   end

   // ----------------------------------------------------------------------
   // Count control
   // ----------------------------------------------------------------------
   mode_e mode0;
   mode_e mode1;
   assign mode0 = mode_e'(timer_mode_select_q[BIT_TIMER0_MODE_HIGH:BIT_TIMER0_MODE_LOW]);
   assign mode1 = mode_e'(timer_mode_select_q[BIT_TIMER1_MODE_HIGH:BIT_TIMER1_MODE_LOW]);

   wire run0_bit = timer_control_flags_q[BIT_TIMER0_RUN_BIT];
   wire run1_bit = timer_control_flags_q[BIT_TIMER1_RUN_BIT];
   wire t0_run   = run0_bit & (~timer_mode_select_q[BIT_TIMER0_GATE_ENABLE] | pin_filt[2]);
   wire t1_run   = run1_bit & (~timer_mode_select_q[BIT_TIMER1_GATE_ENABLE] | pin_filt[3]);
   wire t0_src   = timer_mode_select_q[BIT_TIMER0_SOURCE_SELECT] ? pin_fall[0] : tick;
   wire t1_src   = timer_mode_select_q[BIT_TIMER1_SOURCE_SELECT] ? pin_fall[1] : tick;
   wire t0_evt   = t0_run & t0_src;
   wire t1_evt   = t1_run & t1_src;
   wire split0   = (mode0 == MODE_SPLIT);
   wire th0_evt  = split0 & run1_bit & tick;

   // One step of a timer in its selected mode; split mode holds here.
   function automatic cnt_s count_step(input mode_e m, input logic [7:0] hi, input logic [7:0] lo,
                                       input logic evt);
      cnt_s        r;
      logic [13:0] s13;
      logic [16:0] s16;
      logic [8:0]  s8;
      r.hi = hi;
      r.lo = lo;
      r.ovf = 1'b0;
      s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      s16 = {1'b0, hi, lo} + 17'h00001;
      s8  = {1'b0, lo} + 9'h001;
      if (evt) begin
         case (m)
            MODE_13BIT: begin
               // Top three low bits are left alone and play no part.
               r.hi  = s13[12:5];
               r.lo  = {lo[7:5], s13[4:0]};
               r.ovf = s13[13];
            end
            MODE_16BIT: begin
               r.hi  = s16[15:8];
               r.lo  = s16[7:0];
               r.ovf = s16[16];
            end
            MODE_RELOAD: begin
               r.lo  = s8[8] ? hi : s8[7:0];
               r.ovf = s8[8];
            end
            default: begin
               r.ovf = 1'b0;
            end
         endcase
      end
      return r;
   endfunction

   cnt_s t0_step;
   cnt_s t1_step;
   assign t0_step = count_step(mode0, timer0_count_high_q, timer0_count_low_q, t0_evt);
   assign t1_step = count_step(mode1, timer1_count_high_q, timer1_count_low_q, t1_evt);

   wire [8:0] tl0_split = {1'b0, timer0_count_low_q} + 9'h001;
   wire [8:0] th0_split = {1'b0, timer0_count_high_q} + 9'h001;
   wire       tl0_split_ovf = t0_evt & tl0_split[8];
   wire       th0_split_ovf = th0_evt & th0_split[8];

   wire [7:0] t0_lo_next = split0 ? (t0_evt ? tl0_split[7:0] : timer0_count_low_q) : t0_step.lo;
   wire [7:0] t0_hi_next = split0 ? (th0_evt ? th0_split[7:0] : timer0_count_high_q) : t0_step.hi;

   wire tf0_set = split0 ? tl0_split_ovf : t0_step.ovf;
   wire tf1_set = split0 ? th0_split_ovf : t1_step.ovf;

   // ----------------------------------------------------------------------
   // Register access decode
   // ----------------------------------------------------------------------
   wire wr_timer_control_flags = reg_req.wr & (reg_req.addr == ADDR_TIMER_CONTROL_FLAGS);
   wire wr_timer_mode_select = reg_req.wr & (reg_req.addr == ADDR_TIMER_MODE_SELECT);
   wire wr_tl0  = reg_req.wr & (reg_req.addr == ADDR_TIMER0_COUNT_LOW);
   wire wr_tl1  = reg_req.wr & (reg_req.addr == ADDR_TIMER1_COUNT_LOW);
   wire wr_th0  = reg_req.wr & (reg_req.addr == ADDR_TIMER0_COUNT_HIGH);
   wire wr_th1  = reg_req.wr & (reg_req.addr == ADDR_TIMER1_COUNT_HIGH);
   wire wr_ie   = reg_req.wr & (reg_req.addr == ADDR_INTERRUPT_ENABLE_MASK);
   wire wr_ip   = reg_req.wr & (reg_req.addr == ADDR_INTERRUPT_PRIORITY_SELECT);

   assign timer0_count_low_d  = wr_tl0 ? reg_req.wdata : t0_lo_next;
   assign timer0_count_high_d = wr_th0 ? reg_req.wdata : t0_hi_next;
   assign timer1_count_low_d  = wr_tl1 ? reg_req.wdata : t1_step.lo;
   assign timer1_count_high_d = wr_th1 ? reg_req.wdata : t1_step.hi;

   wire ack0 = irq_ack & (irq_ack_vector == TIMER0_VECTOR);
   wire ack1 = irq_ack & (irq_ack_vector == TIMER1_VECTOR);

   wire [7:0] timer_control_flags_base = wr_timer_control_flags ? reg_req.wdata : timer_control_flags_q;
   wire       tf0_keep  = wr_timer_control_flags ? reg_req.wdata[BIT_TIMER0_OVERFLOW_FLAG]
                                  : timer_control_flags_q[BIT_TIMER0_OVERFLOW_FLAG] & ~ack0;
   wire       tf1_keep  = wr_timer_control_flags ? reg_req.wdata[BIT_TIMER1_OVERFLOW_FLAG]
                                  : timer_control_flags_q[BIT_TIMER1_OVERFLOW_FLAG] & ~ack1;

   // A hardware overflow in the same cycle as a clear still sets the flag.
   always_comb begin
      timer_control_flags_d = timer_control_flags_base;
      timer_control_flags_d[BIT_TIMER0_OVERFLOW_FLAG] = tf0_keep | tf0_set;
      timer_control_flags_d[BIT_TIMER1_OVERFLOW_FLAG] = tf1_keep | tf1_set;
   end

   // Read data mux for the cycle after a read strobe.
   always_comb begin
      if (!reg_req.rd) begin
         rdata_d = UNMAPPED_READ;
      end else if (reg_req.addr == ADDR_TIMER_CONTROL_FLAGS) begin
         rdata_d = timer_control_flags_q;
      end else if (reg_req.addr == ADDR_TIMER_MODE_SELECT) begin
         rdata_d = timer_mode_select_q;
      end else if (reg_req.addr == ADDR_TIMER0_COUNT_LOW) begin
         rdata_d = timer0_count_low_q;
      end else if (reg_req.addr == ADDR_TIMER1_COUNT_LOW) begin
         rdata_d = timer1_count_low_q;
      end else if (reg_req.addr == ADDR_TIMER0_COUNT_HIGH) begin
         rdata_d = timer0_count_high_q;
      end else if (reg_req.addr == ADDR_TIMER1_COUNT_HIGH) begin
         rdata_d = timer1_count_high_q;
      end else if (reg_req.addr == ADDR_INTERRUPT_ENABLE_MASK) begin
         rdata_d = interrupt_enable_mask_q;
      end else if (reg_req.addr == ADDR_INTERRUPT_PRIORITY_SELECT) begin
         rdata_d = interrupt_priority_select_q;
      end else begin
         rdata_d = UNMAPPED_READ;
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt request terms
   // ----------------------------------------------------------------------
   wire irq0_d = timer_control_flags_q[BIT_TIMER0_OVERFLOW_FLAG]
               & interrupt_enable_mask_q[BIT_GLOBAL_IRQ_ENABLE]
               & interrupt_enable_mask_q[BIT_TIMER0_IRQ_ENABLE];
   wire irq1_d = timer_control_flags_q[BIT_TIMER1_OVERFLOW_FLAG]
               & interrupt_enable_mask_q[BIT_GLOBAL_IRQ_ENABLE]
               & interrupt_enable_mask_q[BIT_TIMER1_IRQ_ENABLE];

   // ----------------------------------------------------------------------
   // State update
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         timer_control_flags_q <= RST_CONTROL_FLAGS;
         timer_mode_select_q   <= RST_MODE_SELECT;
         timer0_count_low_q    <= RST_COUNT;
         timer0_count_high_q   <= RST_COUNT;
         timer1_count_low_q    <= RST_COUNT;
         timer1_count_high_q   <= RST_COUNT;
      end else begin
         timer_control_flags_q <= timer_control_flags_d;
         timer_mode_select_q   <= wr_timer_mode_select ? reg_req.wdata : timer_mode_select_q;
         timer0_count_low_q    <= timer0_count_low_d;
         timer0_count_high_q   <= timer0_count_high_d;
         timer1_count_low_q    <= timer1_count_low_d;
         timer1_count_high_q   <= timer1_count_high_d;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         interrupt_enable_mask_q     <= RST_IRQ_ENABLE;
         interrupt_priority_select_q <= RST_IRQ_PRIORITY;
         rdata_q                     <= UNMAPPED_READ;
         irq0_q                      <= 1'b0;
         irq1_q                      <= 1'b0;
         ovf_pulse_q                 <= 1'b0;
      end else begin
         interrupt_enable_mask_q     <= wr_ie ? reg_req.wdata : interrupt_enable_mask_q;
         interrupt_priority_select_q <= wr_ip ? (reg_req.wdata & PRIORITY_IMPL_MASK)
                                              : interrupt_priority_select_q;
         rdata_q                     <= rdata_d;
         irq0_q                      <= irq0_d;
         irq1_q                      <= irq1_d;
         ovf_pulse_q                 <= t1_step.ovf;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign reg_rdata             = rdata_q;
   assign timer0_irq_req        = irq0_q;
   assign timer1_irq_req        = irq1_q;
   assign timer0_irq_high       = interrupt_priority_select_q[BIT_TIMER0_IRQ_PRIORITY];
   assign timer1_irq_high       = interrupt_priority_select_q[BIT_TIMER1_IRQ_PRIORITY];
   assign timer1_overflow_pulse = ovf_pulse_q;

endmodule

// [test/dual_timer_counter_block_monitor.sv]
/* Port checker for the dual timer block.
   Assumes timer_pkg and the top module's port names; bound below. */
`timescale 1ns/100ps
module dual_timer_counter_block_monitor (
   // Clock and reset
   input wire logic                core_clk,
   input wire logic                resetn,
   // Register port
   input wire timer_pkg::reg_req_s reg_req,
   input wire logic [7:0]          reg_rdata,
   // Acknowledge and requests
   input wire logic                irq_ack,
   input wire logic [15:0]         irq_ack_vector,
   input wire logic                timer0_irq_req,
   input wire logic                timer1_irq_req,
   input wire logic                timer0_irq_high,
   input wire logic                timer1_irq_high,
   input wire logic                timer1_overflow_pulse
);
   import timer_pkg::*;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire logic wr_ip  = reg_req.wr && reg_req.addr == ADDR_INTERRUPT_PRIORITY_SELECT;
   wire logic wr_ctl = reg_req.wr && reg_req.addr == ADDR_TIMER_CONTROL_FLAGS;
   wire logic plain  = reg_req.addr inside {8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'hA8};
   wire logic mapped = plain || reg_req.addr inside {8'h88, 8'hB8};
   AST_RDATA_IDLE:
      assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
   AST_READBACK:
      assert property (reg_req.rd && plain && $past(reg_req.wr) && $past(reg_req.addr) == reg_req.addr
         |=> reg_rdata == $past(reg_req.wdata, 2)) else $error("write not read back");
   AST_PRIO_TOP:
      assert property (reg_req.rd && reg_req.addr == ADDR_INTERRUPT_PRIORITY_SELECT
         |=> reg_rdata[7:6] == 2'h0) else $error("priority top bits not zero");
   AST_UNMAPPED:
      assert property (reg_req.rd && !mapped |=> reg_rdata == UNMAPPED_READ) else $error("unmapped read");
   AST_ACK0:
      assert property (irq_ack && irq_ack_vector == TIMER0_VECTOR && !wr_ctl |-> ##2 !timer0_irq_req)
         else $error("timer0 request kept after ack");
   AST_ACK1:
      assert property (irq_ack && irq_ack_vector == TIMER1_VECTOR && !wr_ctl |-> ##2 !timer1_irq_req)
         else $error("timer1 request kept after ack");
   AST_HIGH_FOLLOW:
      assert property (wr_ip ##1 !wr_ip |-> ##2 timer0_irq_high == $past(reg_req.wdata[1], 3)
         && timer1_irq_high == $past(reg_req.wdata[3], 3)) else $error("priority outputs wrong");
   AST_HIGH_STABLE:
      assert property (!$past(wr_ip) && !$past(wr_ip, 2) && !$past(wr_ip, 3)
         |-> $stable(timer0_irq_high) && $stable(timer1_irq_high)) else $error("priority moved");
   AST_PULSE_ONE:
      assert property (timer1_overflow_pulse |=> !timer1_overflow_pulse) else $error("pulse too long");
   cover property (timer0_irq_req);
   cover property (timer1_overflow_pulse);
   cover property (irq_ack && irq_ack_vector == TIMER1_VECTOR);
endmodule
bind dual_timer_counter_block dual_timer_counter_block_monitor dual_timer_counter_block_monitor_i (
   .core_clk(core_clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
   .irq_ack_vector(irq_ack_vector), .timer0_irq_req(timer0_irq_req), .timer1_irq_req(timer1_irq_req),
   .timer0_irq_high(timer0_irq_high), .timer1_irq_high(timer1_irq_high),
   .timer1_overflow_pulse(timer1_overflow_pulse));

// [test/timer_pin_source.sv]
/* Model of the count and gate pins of both timers.
   Assumes its tasks are called just after a rising clock edge. */
`timescale 1ns/100ps
module timer_pin_source (
   // Clock
   input  wire logic core_clk,
   // Pins
   output logic      timer0_count_pin,
   output logic      timer1_count_pin,
   output logic      timer0_gate_pin,
   output logic      timer1_gate_pin
);
   logic [1:0] cnt_q  = 2'h3;
   logic [1:0] gate_q = 2'h0;
   assign {timer1_count_pin, timer0_count_pin} = cnt_q;
   assign {timer1_gate_pin, timer0_gate_pin}   = gate_q;
   // Each level is held four clocks so the synchroniser sees every edge.
   task pulses(input int t, input int n);
      for (int p = 0; p < n; p++) begin
         cnt_q[t] <= 1'h0;
         repeat (4) @(posedge core_clk);
         cnt_q[t] <= 1'h1;
         repeat (4) @(posedge core_clk);
      end
   endtask
   // The gate pin is driven to v and held there until the next call.
   task gate(input int t, input logic v);
      gate_q[t] <= v;
      @(posedge core_clk);
   endtask
endmodule

// [test/dual_timer_counter_block_bench.sv]
/* Self-checking bench for the dual timer block.
   Assumes the design, its bound monitor and the pin source model. */
`timescale 1ns/100ps
module dual_timer_counter_block_bench;
   import timer_pkg::*;
   logic        core_clk = 1'h0;
   logic        resetn   = 1'h0;
   reg_req_s    req      = '0;
   logic        irq_ack  = 1'h0;
   logic [15:0] vec      = 16'h0000;
   logic [7:0]  rdata, q, q2;
   logic        c0, c1, g0, g1, rq0, rq1, hi0, hi1, pulse;
   int          fail_count = 0, n_compared = 0, pulse_n = 0, i, j, k, m;
   logic [7:0]  rows [9][3] = '{'{8'h89, 8'hA5, 8'hA5}, '{8'h8A, 8'h3C, 8'h3C}, '{8'h8B, 8'h7E, 8'h7E},
      '{8'h8C, 8'h81, 8'h81}, '{8'h8D, 8'h42, 8'h42}, '{8'hA8, 8'h8A, 8'h8A}, '{8'hB8, 8'hFF, 8'h3F},
      '{8'h88, 8'h0F, 8'h0F}, '{8'h90, 8'h55, 8'h00}};
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) if (pulse) pulse_n <= pulse_n + 1;
   dual_timer_counter_block dual_timer_counter_block_i (.core_clk(core_clk), .resetn(resetn),
      .reg_req(req), .reg_rdata(rdata), .irq_ack(irq_ack), .irq_ack_vector(vec), .timer0_count_pin(c0),
      .timer1_count_pin(c1), .timer0_gate_pin(g0), .timer1_gate_pin(g1), .timer0_irq_req(rq0),
      .timer1_irq_req(rq1), .timer0_irq_high(hi0), .timer1_irq_high(hi1), .timer1_overflow_pulse(pulse));
   timer_pin_source timer_pin_source_i (.core_clk(core_clk), .timer0_count_pin(c0),
      .timer1_count_pin(c1), .timer0_gate_pin(g0), .timer1_gate_pin(g1));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask
   // Kind 0 writes, 1 reads, 2 writes then reads back to back; read data lands in q.
   task acc(input logic [7:0] a, input logic [7:0] d, input int kind);
      if (kind != 1) begin
         req <= {a, d, 2'h2};
         @(posedge core_clk);
      end
      if (kind != 0) begin
         req <= {a, d, 2'h1};
         @(posedge core_clk);
      end
      req <= {a, d, 2'h0};
      #1 q = rdata;
      @(posedge core_clk);
   endtask
   task finish_test;
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task wait_bit(input int b);
      for (k = 0; k < 60; k++) begin
         acc(ADDR_TIMER_CONTROL_FLAGS, 8'h00, 1);
         if (q[b] === 1'h1) return;
      end
      fail_count++;
      $display("Error %0t: flag wait timed out", $time);
      finish_test();
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      resetn <= 1'h1;
      @(posedge core_clk);
      for (i = 0; i < 9; i++) begin
         acc(rows[i][0], 8'h00, 1);
         chk(q, 8'h00);
      end
      for (i = 0; i < 9; i++) begin
         acc(rows[i][0], rows[i][1], 2);
         chk(q, rows[i][2]);
      end
      chk({6'h00, hi1, hi0}, 8'h03);
      for (i = 0; i < 2; i++) begin
         acc(ADDR_TIMER_MODE_SELECT, i ? 8'hD0 : 8'h0D, 0);
         acc(ADDR_TIMER0_COUNT_LOW + i[7:0], 8'h00, 0);
         acc(ADDR_TIMER_CONTROL_FLAGS, i ? 8'h40 : 8'h10, 0);
         timer_pin_source_i.pulses(i, 3);
         repeat (8) @(posedge core_clk);
         acc(ADDR_TIMER0_COUNT_LOW + i[7:0], 8'h00, 1);
         chk(q, 8'h00);
         timer_pin_source_i.gate(i, 1'h1);
         timer_pin_source_i.pulses(i, 5);
         repeat (8) @(posedge core_clk);
         acc(ADDR_TIMER0_COUNT_LOW + i[7:0], 8'h00, 1);
         chk(q, 8'h05);
         timer_pin_source_i.gate(i, 1'h0);
      end
      acc(ADDR_TIMER_MODE_SELECT, 8'h00, 0);
      acc(ADDR_TIMER0_COUNT_HIGH, 8'hFF, 0);
      acc(ADDR_TIMER0_COUNT_LOW, 8'hFF, 0);
      acc(ADDR_TIMER_CONTROL_FLAGS, 8'h10, 0);
      wait_bit(5);
      acc(ADDR_TIMER_CONTROL_FLAGS, 8'h00, 0);
      acc(ADDR_TIMER0_COUNT_LOW, 8'h00, 1);
      chk(q, 8'hE0);
      acc(ADDR_TIMER0_COUNT_HIGH, 8'h00, 1);
      chk(q, 8'h00);
      acc(ADDR_TIMER_CONTROL_FLAGS, 8'h10, 0);
      acc(ADDR_TIMER0_COUNT_LOW, 8'h00, 1);
      q2 = q;
      m = -1;
      for (j = 0; j < 40; j++) begin
         acc(ADDR_TIMER0_COUNT_LOW, 8'h00, 1);
         if (q !== q2) begin
            if (m >= 0) break;
            m = 0;
            q2 = q;
         end else if (m >= 0) m++;
      end
      chk(m[7:0], 8'h05);
      acc(ADDR_TIMER_MODE_SELECT, 8'h02, 0);
      acc(ADDR_TIMER0_COUNT_HIGH, 8'hF0, 0);
      acc(ADDR_TIMER0_COUNT_LOW, 8'hFE, 0);
      wait_bit(5);
      acc(ADDR_TIMER_CONTROL_FLAGS, 8'h00, 0);
      acc(ADDR_TIMER0_COUNT_LOW, 8'h00, 1);
      chk(q, 8'hF0);
      acc(ADDR_TIMER0_COUNT_HIGH, 8'h00, 1);
      chk(q, 8'hF0);
      acc(ADDR_TIMER_MODE_SELECT, 8'h23, 0);
      acc(ADDR_TIMER0_COUNT_LOW, 8'h00, 0);
      acc(ADDR_TIMER0_COUNT_HIGH, 8'hFF, 0);
      acc(ADDR_TIMER1_COUNT_LOW, 8'hFE, 0);
      acc(ADDR_TIMER1_COUNT_HIGH, 8'h00, 0);
      acc(ADDR_TIMER_CONTROL_FLAGS, 8'h40, 0);
      wait_bit(7);
      repeat (30) @(posedge core_clk);
      acc(ADDR_TIMER0_COUNT_LOW, 8'h00, 1);
      chk(q, 8'h00);
      chk({7'h00, pulse_n > 0}, 8'h01);
      acc(ADDR_TIMER_MODE_SELECT, 8'h33, 0);
      acc(ADDR_TIMER1_COUNT_LOW, 8'h00, 1);
      q2 = q;
      repeat (30) @(posedge core_clk);
      acc(ADDR_TIMER1_COUNT_LOW, 8'h00, 1);
      chk(q, q2);
      acc(ADDR_TIMER_CONTROL_FLAGS, 8'h00, 0);
      for (i = 0; i < 2; i++) begin
         acc(ADDR_INTERRUPT_ENABLE_MASK, i ? 8'h88 : 8'h82, 0);
         acc(ADDR_TIMER_CONTROL_FLAGS, i ? 8'h80 : 8'h20, 0);
         repeat (2) @(posedge core_clk);
         #1 chk({7'h00, i ? rq1 : rq0}, 8'h01);
         acc(ADDR_INTERRUPT_ENABLE_MASK, i ? 8'h08 : 8'h02, 0);
         repeat (2) @(posedge core_clk);
         #1 chk({7'h00, i ? rq1 : rq0}, 8'h00);
         acc(ADDR_INTERRUPT_ENABLE_MASK, i ? 8'h88 : 8'h82, 0);
         irq_ack <= 1'h1;
         vec <= i ? TIMER1_VECTOR : TIMER0_VECTOR;
         @(posedge core_clk);
         irq_ack <= 1'h0;
         repeat (2) @(posedge core_clk);
         #1 chk({7'h00, i ? rq1 : rq0}, 8'h00);
         acc(ADDR_TIMER_CONTROL_FLAGS, 8'h00, 1);
         chk(q, 8'h00);
      end
      // A reset in mid-run must bring the pulse, request and priority outputs and the priority register back to zero.
      resetn <= 1'h0;
      repeat (2) @(posedge core_clk);
      resetn <= 1'h1;
      @(posedge core_clk);
      chk({3'h0, pulse, rq1, rq0, hi1, hi0}, 8'h00);
      acc(ADDR_INTERRUPT_PRIORITY_SELECT, 8'h00, 1);
      chk(q, RST_IRQ_PRIORITY);
      finish_test();
   end
endmodule
